// *** hdl/program_loop_watchdog.sv ***
// Program loop watchdog with AXI4-Lite registers and one level interrupt.
// Assumes low_speed_clk is the free-running low-speed oscillator pin and
// standby_stop comes from power control logic on mclk.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
// Contract
// RULE1: Counter advances only on edges of the low-speed oscillator clock.
// RULE2: Counter overflow without restart raises the internal reset.
// RULE3: A single-bit access to the restart register raises the internal reset.
// RULE4: Writing any value except the key to the restart register resets.
// RULE5: Writing the restart register while the window is closed resets.
// RULE6: A watchdog reset sets bit 4 of the reset cause register.
// RULE7: Interval interrupt raised when count reaches 75 percent of overflow.
// RULE8: In standby the counter runs only with both option bits set.
// RULE9: Software writes the key in the open window; counter restarts from zero.
module program_loop_watchdog #(
	parameter int COUNT_W = 12,
	parameter logic [COUNT_W-1:0] OVERFLOW_TICKS = 12'h800
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// Low-speed oscillator and power state
	input wire logic low_speed_clk,
	input wire logic standby_stop,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Results
	output logic watchdog_reset,
	output logic irq
);
	localparam logic [COUNT_W-1:0] INTERVAL_POINT = COUNT_W'((OVERFLOW_TICKS / 4) * 3);
	localparam logic [COUNT_W-1:0] QUARTER = COUNT_W'(OVERFLOW_TICKS / 4);
	localparam logic [COUNT_W-1:0] HALF = COUNT_W'(OVERFLOW_TICKS / 2);
	localparam int HOLD_W = $clog2(wdt_pkg::RESET_HOLD_CYCLES + 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(wdt_pkg::RESET_HOLD_CYCLES - 1);

	logic ls_rise;
	logic [COUNT_W-1:0] count;
	logic [4:0] ctrl;
	logic cause_flag;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic do_read;
	logic [7:0] rd_addr;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic werr;
	wdt_pkg::reset_state_type state;
	logic [HOLD_W-1:0] hold_count;
	wdt_pkg::window_type win_sel;
	logic [COUNT_W-1:0] closed_limit;
	logic window_closed;
	logic run;
	logic advance;
	logic overflow_event;
	logic interval_event;
	logic restart_write;
	logic bitop_fault;
	logic key_fault;
	logic window_fault;
	logic good_restart;
	logic fault_event;
	logic clear_count;

	// ==========================================
	// Low-speed clock sampling and counter
	// RULE1: only low-speed edges step the count
	pin_sync ls_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.pin(low_speed_clk),
		.level(),
		.rise(ls_rise)
	);

	lowspeed_counter #(.W(COUNT_W)) counter (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.advance(advance),
		.clear(clear_count),
		.count(count)
	);

	// RULE8: standby needs both option bits
	assign run = ctrl[wdt_pkg::CTRL_ON_BIT] && (!standby_stop || ctrl[wdt_pkg::CTRL_STBY_BIT]);
	assign advance = ls_rise && run && (state == wdt_pkg::WDT_RUNNING);

	// ==========================================
	// Fault detection
	// RULE2: overflow point reached unrestarted
	assign overflow_event = advance && (count == OVERFLOW_TICKS - 1'b1);
	// RULE7: interval warning at three quarters
	assign interval_event = advance && (count == INTERVAL_POINT - 1'b1);

	// Closed part of the period, selected in control
	assign win_sel = wdt_pkg::window_type'(ctrl[wdt_pkg::CTRL_WIN_LSB +: 2]);
	always_comb begin
		unique case (win_sel)
			wdt_pkg::WIN_75: closed_limit = QUARTER;
			wdt_pkg::WIN_50: closed_limit = HALF;
			wdt_pkg::WIN_FULL, wdt_pkg::WIN_RSVD: closed_limit = '0;
		endcase
	end
	assign window_closed = count < closed_limit;

	// Restart writes need lane 0; other lanes alone are ignored
	assign restart_write = do_write && (aw_addr == wdt_pkg::OFS_RESTART) && w_strb[0];
	// RULE3: any write to the bit-operation alias
	assign bitop_fault = do_write && (aw_addr == wdt_pkg::OFS_BITOP);
	// RULE4: wrong key value
	assign key_fault = restart_write && (w_data[7:0] != wdt_pkg::RESTART_KEY);
	// RULE5: key inside the closed window still faults
	assign window_fault = restart_write && !key_fault && window_closed;
	// RULE9: correct key in the open window restarts
	assign good_restart = restart_write && !key_fault && !window_closed;

	assign fault_event = (state == wdt_pkg::WDT_RUNNING) && run &&
		(overflow_event || bitop_fault || key_fault || window_fault);
	assign clear_count = good_restart || fault_event || (state == wdt_pkg::WDT_RESETTING);

	// ==========================================
	// Internal reset pulse; fixed hold keeps it visible to slow reset trees
	// RULE2: assert internal reset on fault
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= wdt_pkg::WDT_RUNNING;
			hold_count <= '0;
		end else if (ce) begin
			unique case (state)
				wdt_pkg::WDT_RUNNING: begin
					hold_count <= '0;
					if (fault_event) begin
						state <= wdt_pkg::WDT_RESETTING;
					end
				end
				wdt_pkg::WDT_RESETTING: begin
					hold_count <= hold_count + 1'b1;
					if (hold_count == HOLD_LAST) begin
						state <= wdt_pkg::WDT_RUNNING;
					end
				end
			endcase
		end
	end
	assign watchdog_reset = (state == wdt_pkg::WDT_RESETTING);

	// ==========================================
	// Cause flag; survives the internal reset, read clears, set wins
	// RULE6: watchdog reset marks its cause
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cause_flag <= 1'b0;
		end else if (ce) begin
			if (fault_event) begin
				cause_flag <= 1'b1;
			end else if (do_read && rd_addr == wdt_pkg::OFS_CAUSE) begin
				cause_flag <= 1'b0;
			end
		end
	end

	// Sticky interrupt status, read clears, set wins
	// RULE7: interval event gated by its enable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= '0;
		end else if (ce) begin
			if (do_read && rd_addr == wdt_pkg::OFS_IRQ_STATUS) begin
				irq_status <= '0;
			end
			if (interval_event && ctrl[wdt_pkg::CTRL_INT_EN_BIT]) begin
				irq_status[wdt_pkg::IRQ_INTERVAL_BIT] <= 1'b1;
			end
			if (fault_event) begin
				irq_status[wdt_pkg::IRQ_FAULT_BIT] <= 1'b1;
			end
		end
	end
	assign irq = |(irq_status & irq_mask);

	// ==========================================
	// AXI4-Lite write side; address and data taken in either order
	assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
	assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
	assign do_write = ce && aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Decode of writable offsets
	assign werr = !(aw_addr == wdt_pkg::OFS_CTRL || aw_addr == wdt_pkg::OFS_RESTART ||
		aw_addr == wdt_pkg::OFS_BITOP || aw_addr == wdt_pkg::OFS_IRQ_MASK);

	// Write response and register update
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= wdt_pkg::AXI_OKAY;
			ctrl <= wdt_pkg::CTRL_RESET;
			irq_mask <= wdt_pkg::IRQ_MASK_RESET;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= werr ? wdt_pkg::AXI_SLVERR : wdt_pkg::AXI_OKAY;
				if (aw_addr == wdt_pkg::OFS_CTRL && w_strb[0]) begin
					ctrl <= w_data[4:0];
				end
				if (aw_addr == wdt_pkg::OFS_IRQ_MASK && w_strb[0]) begin
					irq_mask <= w_data[1:0];
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// AXI4-Lite read side; one read outstanding
	assign s_axi_arready = ce && !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_addr = {s_axi_araddr[7:2], 2'b00};

	// Read mux; unused bits read zero
	always_comb begin
		next_rdata = '0;
		next_rerr = 1'b0;
		unique case (rd_addr)
			wdt_pkg::OFS_CTRL: next_rdata[4:0] = ctrl;
			wdt_pkg::OFS_RESTART, wdt_pkg::OFS_BITOP: next_rdata = '0;
			wdt_pkg::OFS_COUNT: next_rdata[COUNT_W-1:0] = count;
			wdt_pkg::OFS_CAUSE: next_rdata[wdt_pkg::CAUSE_WDT_BIT] = cause_flag;
			wdt_pkg::OFS_IRQ_STATUS: next_rdata[1:0] = irq_status;
			wdt_pkg::OFS_IRQ_MASK: next_rdata[1:0] = irq_mask;
			default: next_rerr = 1'b1;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= wdt_pkg::AXI_OKAY;
		end else if (ce) begin
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rerr ? wdt_pkg::AXI_SLVERR : wdt_pkg::AXI_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	count_source_a: assert property ( // RULE1
		ce && count != $past(count) && !$past(clear_count) |-> $past(ls_rise))
		else $error("count moved without a low-speed edge");
	overflow_reset_a: assert property ( // RULE2
		ce && overflow_event && state == wdt_pkg::WDT_RUNNING |=> watchdog_reset && count == '0)
		else $error("overflow did not raise reset");
	bitop_reset_a: assert property ( // RULE3
		ce && bitop_fault && run && !watchdog_reset |=> watchdog_reset)
		else $error("bit access did not raise reset");
	key_reset_a: assert property ( // RULE4
		ce && key_fault && run && !watchdog_reset |=> watchdog_reset)
		else $error("wrong key did not raise reset");
	window_reset_a: assert property ( // RULE5
		ce && restart_write && w_data[7:0] == wdt_pkg::RESTART_KEY
		&& window_closed && run && !watchdog_reset |=> watchdog_reset)
		else $error("closed window write did not reset");
	cause_flag_a: assert property ( // RULE6
		ce && $rose(watchdog_reset) |-> cause_flag)
		else $error("cause flag not set by watchdog reset");
	interval_irq_a: assert property ( // RULE7
		ce && interval_event && ctrl[wdt_pkg::CTRL_INT_EN_BIT]
		|=> irq_status[wdt_pkg::IRQ_INTERVAL_BIT] && count == INTERVAL_POINT)
		else $error("interval status missing at three quarters");
	// Count change at an edge follows the standby state sampled one edge earlier
	standby_stop_a: assert property ( // RULE8
		ce && $past(standby_stop) && !$past(ctrl[wdt_pkg::CTRL_STBY_BIT])
		&& !$past(clear_count) |-> $stable(count))
		else $error("counter ran in standby");
	restart_zero_a: assert property ( // RULE9
		ce && good_restart && !fault_event |=> count == '0 && !watchdog_reset)
		else $error("good restart did not clear count");
	reset_hold_a: assert property ( // RULE2
		ce && $rose(watchdog_reset) |-> watchdog_reset[*8])
		else $error("internal reset too short");
	fault_status_a: assert property ( // RULE2
		ce && $rose(watchdog_reset) |-> irq_status[wdt_pkg::IRQ_FAULT_BIT])
		else $error("fault status missing at internal reset");

	restart_seen_c: cover property (good_restart ##1 count == '0);
	overflow_seen_c: cover property (overflow_event ##1 watchdog_reset);
	interval_seen_c: cover property (interval_event ##1 irq);
	window_seen_c: cover property (window_fault);
endmodule

// *** hdl/wdt_pkg.sv ***
// Constants shared by the program loop watchdog and its testbench.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package wdt_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RESTART = 8'h04;
	localparam logic [7:0] OFS_BITOP = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_CAUSE = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	// ==========================================
	// Field positions and reset values
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_STBY_BIT = 1;
	localparam int CTRL_WIN_LSB = 2;
	localparam int CTRL_INT_EN_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h01;
	localparam logic [7:0] RESTART_KEY = 8'hac;
	localparam int CAUSE_WDT_BIT = 4;
	localparam int IRQ_INTERVAL_BIT = 0;
	localparam int IRQ_FAULT_BIT = 1;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_HOLD_NS = 200;
	localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================
	// Types
	typedef enum logic [1:0] {WIN_FULL, WIN_75, WIN_50, WIN_RSVD} window_type;
	typedef enum logic {WDT_RUNNING, WDT_RESETTING} reset_state_type;
endpackage

// *** hdl/pin_sync.sv ***
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to mclk and slower than mclk / 4.
`timescale 1ns/10ps
module pin_sync (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// Pin and filtered result
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic stage1;
	logic stage2;
	logic stage3;

	// ==========================================
	// Chain; stage1 feeds only stage2
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else if (ce) begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Level follows only when two late stages agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
			rise <= 1'b0;
		end else if (ce) begin
			rise <= (stage2 == stage3) && stage3 && !level;
			if (stage2 == stage3) begin
				level <= stage3;
			end
		end
	end
endmodule

// *** hdl/lowspeed_counter.sv ***
// Up counter advanced by low-speed clock ticks, with synchronous clear.
// Assumes advance is a one-cycle pulse on mclk.
`timescale 1ns/10ps
module lowspeed_counter #(
	parameter int W = 12
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// Control
	input wire logic advance,
	input wire logic clear,
	// Count value
	output logic [W-1:0] count
);
	// ==========================================
	// Clear beats advance so a restart is never lost
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (ce) begin
			if (clear) begin
				count <= '0;
			end else if (advance) begin
				count <= count + 1'b1;
			end
		end
	end
endmodule

// *** test/tb_program_loop_watchdog.sv ***
// Self-checking bench for the program loop watchdog, driven over AXI4-Lite.
// Assumes a shortened overflow count of 16 ticks and the package offsets.
`timescale 1ns/10ps
module tb_program_loop_watchdog;
	localparam logic [11:0] OVF = 12'h010;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic low_speed_clk = 1'b0;
	logic standby_stop = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic watchdog_reset;
	logic irq;
	int error_cnt = 0;
	int n_tests = 0;
	int run_len = 0;
	int last_len = 0;
	int seen = 0;
	int base = 0;
	logic [7:0] bad [4] = '{8'h00, 8'hab, 8'had, 8'hff};

	// ==========================================
	// Clock and design
	always #5 mclk = ~mclk;

	program_loop_watchdog #(.COUNT_W(12), .OVERFLOW_TICKS(OVF)) i_program_loop_watchdog (
		.mclk(mclk), .rst_n(rst_n), .ce(ce), .low_speed_clk(low_speed_clk), .standby_stop(standby_stop),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .watchdog_reset(watchdog_reset), .irq(irq)
	);

	// Pulse monitor: counts finished reset pulses and their length in cycles
	always @(posedge mclk) begin
		if (watchdog_reset === 1'b1) begin
			run_len++;
		end else if (run_len != 0) begin
			last_len = run_len;
			seen++;
			run_len = 0;
		end
	end

	// ==========================================
	// Bench tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask

	// Write with both channels offered together; response held until sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic [1:0] r;
		r = 2'h3;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge mclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		chk($sformatf("bresp at %h", a), {30'h0, er}, {30'h0, r});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		logic [1:0] r;
		logic [31:0] d;
		r = 2'h3;
		d = 32'hxxxxxxxx;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge mclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				r = s_axi_rresp;
				d = s_axi_rdata;
				break;
			end
		end
		s_axi_rready <= 1'b0;
		chk($sformatf("rresp at %h", a), {30'h0, er}, {30'h0, r});
		chk($sformatf("rdata at %h", a), ed, d);
	endtask

	// Low-speed ticks, slow enough for the three-flop synchroniser
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge mclk);
			low_speed_clk <= 1'b1;
			repeat (5) @(posedge mclk);
			low_speed_clk <= 1'b0;
			repeat (6) @(posedge mclk);
		end
	endtask

	task automatic expect_fault(input int want);
		int i;
		for (i = 0; i < 80 && seen == base; i++) @(posedge mclk);
		chk("reset pulses", want, seen - base);
		if (want != 0) chk("reset hold", wdt_pkg::RESET_HOLD_CYCLES, last_len);
		base = seen;
	endtask

	task automatic report_and_stop;
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================
	// Watchdog against a hung run
	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end

	// ==========================================
	// Test sequence
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rd(wdt_pkg::OFS_CTRL, 32'h01, wdt_pkg::AXI_OKAY);
		rd(wdt_pkg::OFS_IRQ_MASK, 32'h0, wdt_pkg::AXI_OKAY);
		rd(wdt_pkg::OFS_CAUSE, 32'h0, wdt_pkg::AXI_OKAY);
		rd(8'h1c, 32'h0, wdt_pkg::AXI_SLVERR);
		wr(wdt_pkg::OFS_COUNT, 32'h5, wdt_pkg::AXI_SLVERR);
		tick(5);
		repeat (60) @(posedge mclk);
		rd(wdt_pkg::OFS_COUNT, 32'h5, wdt_pkg::AXI_OKAY);
		wr(wdt_pkg::OFS_RESTART, 32'hac, wdt_pkg::AXI_OKAY);
		rd(wdt_pkg::OFS_COUNT, 32'h0, wdt_pkg::AXI_OKAY);
		expect_fault(0);
		// Interval interrupt at 12 of 16 ticks, then read-clear
		wr(wdt_pkg::OFS_IRQ_MASK, 32'h1, wdt_pkg::AXI_OKAY);
		wr(wdt_pkg::OFS_CTRL, 32'h11, wdt_pkg::AXI_OKAY);
		tick(11);
		chk("irq before 75 percent", 32'h0, {31'h0, irq});
		tick(1);
		chk("irq at 75 percent", 32'h1, {31'h0, irq});
		rd(wdt_pkg::OFS_IRQ_STATUS, 32'h1, wdt_pkg::AXI_OKAY);
		chk("irq after clear", 32'h0, {31'h0, irq});
		// Overflow after a full run of ticks from a fresh restart
		wr(wdt_pkg::OFS_RESTART, 32'hac, wdt_pkg::AXI_OKAY);
		tick(16);
		expect_fault(1);
		rd(wdt_pkg::OFS_CAUSE, 32'h10, wdt_pkg::AXI_OKAY);
		rd(wdt_pkg::OFS_CAUSE, 32'h0, wdt_pkg::AXI_OKAY);
		rd(wdt_pkg::OFS_IRQ_STATUS, 32'h3, wdt_pkg::AXI_OKAY);
		rd(wdt_pkg::OFS_COUNT, 32'h0, wdt_pkg::AXI_OKAY);
		// Each of four wrong key values is a fault
		foreach (bad[k]) begin
			wr(wdt_pkg::OFS_RESTART, {24'h0, bad[k]}, wdt_pkg::AXI_OKAY);
			expect_fault(1);
			rd(wdt_pkg::OFS_CAUSE, 32'h10, wdt_pkg::AXI_OKAY);
		end
		wr(wdt_pkg::OFS_BITOP, 32'hac, wdt_pkg::AXI_OKAY);
		expect_fault(1);
		// Window closed for the first half of the count
		wr(wdt_pkg::OFS_CTRL, 32'h09, wdt_pkg::AXI_OKAY);
		tick(2);
		wr(wdt_pkg::OFS_RESTART, 32'hac, wdt_pkg::AXI_OKAY);
		expect_fault(1);
		tick(10);
		wr(wdt_pkg::OFS_RESTART, 32'hac, wdt_pkg::AXI_OKAY);
		expect_fault(0);
		rd(wdt_pkg::OFS_COUNT, 32'h0, wdt_pkg::AXI_OKAY);
		// Standby stop: counting only with the standby option set
		wr(wdt_pkg::OFS_CTRL, 32'h01, wdt_pkg::AXI_OKAY);
		standby_stop <= 1'b1;
		tick(3);
		rd(wdt_pkg::OFS_COUNT, 32'h0, wdt_pkg::AXI_OKAY);
		wr(wdt_pkg::OFS_CTRL, 32'h03, wdt_pkg::AXI_OKAY);
		tick(3);
		rd(wdt_pkg::OFS_COUNT, 32'h3, wdt_pkg::AXI_OKAY);
		standby_stop <= 1'b0;
		wr(wdt_pkg::OFS_CTRL, 32'h00, wdt_pkg::AXI_OKAY);
		tick(2);
		rd(wdt_pkg::OFS_COUNT, 32'h3, wdt_pkg::AXI_OKAY);
		expect_fault(0);
		// Clock enable low freezes the count; then the quarter window edge
		wr(wdt_pkg::OFS_CTRL, 32'h05, wdt_pkg::AXI_OKAY);
		ce <= 1'b0;
		tick(2);
		ce <= 1'b1;
		rd(wdt_pkg::OFS_COUNT, 32'h3, wdt_pkg::AXI_OKAY);
		tick(1);
		rd(wdt_pkg::OFS_COUNT, 32'h4, wdt_pkg::AXI_OKAY);
		wr(wdt_pkg::OFS_RESTART, 32'hac, wdt_pkg::AXI_OKAY);
		expect_fault(0);
		tick(3);
		wr(wdt_pkg::OFS_RESTART, 32'hac, wdt_pkg::AXI_OKAY);
		expect_fault(1);
		report_and_stop();
	end
endmodule
